// [common/sertx_pkg.sv]
// Package of register map, field layout and state types for the serial transmitter.
`default_nettype none
package sertx_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_TRANSMIT_HOLDING = 12'h000;
	localparam logic [11:0] OFS_FRAME_FORMAT_SELECT = 12'h004;
	localparam logic [11:0] OFS_TX_STATUS = 12'h008;
	localparam logic [11:0] OFS_TX_CONTROL = 12'h00C;
	localparam logic [7:0] RST_TRANSMIT_HOLDING = 8'hFF;
	localparam logic [7:0] RST_FRAME_FORMAT = 8'h00;
	// ------------------------------------------------------------
	// Field positions of the format register
	// ------------------------------------------------------------
	localparam int POS_SYNC_MODE = 7;
	localparam int POS_CHAR_LENGTH = 6;
	localparam int POS_PARITY_ENABLE = 5;
	localparam int POS_PARITY_ODD = 4;
	localparam int POS_TWO_STOP = 3;
	localparam int POS_MULTIPROC = 2;
	// Prescale codes.
	localparam logic [1:0] PRESCALE_SYS = 2'h0;
	localparam logic [1:0] PRESCALE_SUB = 2'h1;
	localparam logic [1:0] PRESCALE_DIV16 = 2'h2;
	localparam logic [1:0] PRESCALE_DIV64 = 2'h3;
	localparam logic [5:0] DIV16_LAST = 6'h0F;
	localparam logic [5:0] DIV64_LAST = 6'h3F;
	// Data bits per character.
	localparam logic [3:0] LEN_8 = 4'h8;
	localparam logic [3:0] LEN_7 = 4'h7;
	localparam logic [3:0] LEN_5 = 4'h5;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b011,
		ST_EXTRA = 3'b010,
		ST_STOP = 3'b110
	} tx_state_t;
	typedef struct packed {
		logic sync_mode;
		logic [3:0] data_bits;
		logic extra_bit;
		logic extra_is_parity;
		logic parity_odd;
		logic two_stop;
	} frame_cfg_t;
endpackage
`default_nettype wire

// [verilog/sertx_prescale.sv]
// Baud source prescaler producing a one-cycle tick per selected clock period.
`default_nettype none
module sertx_prescale (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Selection and subclock ticks.
	input wire logic [1:0] prescale_sel,
	input wire logic sub_tick,
	input wire logic sub_low_power,
	// Output tick.
	output logic tick
);
	typedef struct packed {
		logic [5:0] count;
		logic sub_half;
		logic tick;
	} pre_state_t;
	pre_state_t state;
	pre_state_t next_state;

	// Pass or count the system clock, or halve the subclock unless in low power, as selected.
	always_comb begin
		next_state = state;
		next_state.tick = 1'b0;
		case (prescale_sel)
			sertx_pkg::PRESCALE_SYS: begin
				next_state.tick = 1'b1;
			end
			sertx_pkg::PRESCALE_SUB: begin
				if (sub_tick) begin
					next_state.sub_half = ~state.sub_half;
					next_state.tick = sub_low_power | state.sub_half;
				end
			end
			sertx_pkg::PRESCALE_DIV16: begin
				next_state.count = (state.count >= sertx_pkg::DIV16_LAST) ?
					6'h00 : 6'(state.count + 6'h01);
				next_state.tick = (state.count >= sertx_pkg::DIV16_LAST);
			end
			default: begin
				next_state.count = (state.count == sertx_pkg::DIV64_LAST) ?
					6'h00 : 6'(state.count + 6'h01);
				next_state.tick = (state.count == sertx_pkg::DIV64_LAST);
			end
		endcase
	end

	// Register the state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign tick = state.tick;
endmodule
`default_nettype wire

// [verilog/sertx_top.sv]
// Transmit holding register, frame format register and transmit shifter.
`default_nettype none
// Summary of operation
// - Holding byte loads into empty shifter.
// - New byte accepted while shifter sends.
// - Holding register RW, resets to all ones.
// - Format register RW, resets to zero.
// - Format top bit selects synchronous mode.
// - Length bit picks 8 or 7 bits.
// - Seven-bit frames drop data bit 7.
// - Parity plus multiproc gives five bits.
// - Parity appended only in asynchronous mode.
// - Polarity bit picks even or odd.
// - Polarity ignored without parity or synchronous.
// - One or two high stop bits when asynchronous, none in synchronous mode.
// - Receiver checks only the first stop.
// - Multiproc bit acts only asynchronously.
// - Prescale code selects baud source clock.
// - Subclock halved except in low power.
// - No load while empty flag set.
// - Shifter sends bit zero first.
module sertx_top (
	// Clock, reset and enable.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power mode and clock sources.
	input wire logic standby_enter,
	input wire logic sub_tick,
	input wire logic sub_low_power,
	input wire logic bit_tick,
	// Serial line.
	output logic txd,
	output logic sclk_out,
	output logic prescale_tick,
	output logic tx_busy
);
	typedef struct packed {
		logic [7:0] holding;
		logic [7:0] format;
		logic empty_flag;
		logic tx_enable;
		sertx_pkg::tx_state_t fsm;
		logic [7:0] shifter;
		logic [3:0] bit_count;
		logic [3:0] bits_total;
		logic stop_left;
		logic extra_val;
		sertx_pkg::frame_cfg_t cfg;
		logic parity_acc;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic txd;
		logic sclk_out;
		logic prescale_tick;
		logic tx_busy;
	} top_state_t;
	top_state_t state;
	top_state_t next_state;
	logic pre_tick;
	logic apb_write;
	logic hold_write;
	logic load_now;

	// Decode the format register into frame settings.
	function automatic sertx_pkg::frame_cfg_t decode_cfg(
		input logic [7:0] fmt
	);
		sertx_pkg::frame_cfg_t c;
		logic five;
		c.sync_mode = fmt[sertx_pkg::POS_SYNC_MODE];
		five = fmt[sertx_pkg::POS_PARITY_ENABLE] &
			fmt[sertx_pkg::POS_MULTIPROC];
		if (c.sync_mode) begin
			c.data_bits = sertx_pkg::LEN_8;
		end else if (five) begin
			c.data_bits = sertx_pkg::LEN_5;
		end else if (fmt[sertx_pkg::POS_CHAR_LENGTH]) begin
			c.data_bits = sertx_pkg::LEN_7;
		end else begin
			c.data_bits = sertx_pkg::LEN_8;
		end
		c.extra_bit = ~c.sync_mode & (fmt[sertx_pkg::POS_PARITY_ENABLE] |
			fmt[sertx_pkg::POS_MULTIPROC]);
		c.extra_is_parity = ~c.sync_mode & fmt[sertx_pkg::POS_PARITY_ENABLE];
		c.parity_odd = c.extra_is_parity & fmt[sertx_pkg::POS_PARITY_ODD];
		c.two_stop = ~c.sync_mode & fmt[sertx_pkg::POS_TWO_STOP];
		return c;
	endfunction

	// Mask away data bits above the character length.
	function automatic logic [7:0] length_mask(input logic [3:0] n);
		logic [7:0] m;
		m = 8'hFF;
		if (n == sertx_pkg::LEN_7) begin
			m = 8'h7F;
		end else if (n == sertx_pkg::LEN_5) begin
			m = 8'h1F;
		end
		return m;
	endfunction

	// ------------------------------------------------------------
	// Baud source prescaler
	// ------------------------------------------------------------
	sertx_prescale u_prescale (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.prescale_sel(state.format[1:0]),
		.sub_tick(sub_tick),
		.sub_low_power(sub_low_power),
		.tick(pre_tick)
	);

	assign apb_write = psel & penable & pwrite & ~state.pready;
	assign hold_write = apb_write &
		(paddr == sertx_pkg::OFS_TRANSMIT_HOLDING);
	// The shifter is free when idle or on the tick that ends the last stop.
	assign load_now = bit_tick & state.tx_enable & ~state.empty_flag &
		((state.fsm == sertx_pkg::ST_IDLE) |
		((state.fsm == sertx_pkg::ST_STOP) & ~state.stop_left));

	// Bus access, holding transfer and frame sequencing.
	always_comb begin
		next_state = state;
		next_state.pready = 1'b0;
		next_state.pslverr = 1'b0;
		next_state.prescale_tick = pre_tick;
		// APB answers one cycle into the access phase.
		if (psel & penable & ~state.pready) begin
			next_state.pready = 1'b1;
			next_state.prdata = 32'h0000_0000;
			case (paddr)
				sertx_pkg::OFS_TRANSMIT_HOLDING: begin
					next_state.prdata = {24'h00_0000, state.holding};
					if (apb_write) begin
						next_state.holding = pwdata[7:0];
						next_state.empty_flag = 1'b0;
					end
				end
				sertx_pkg::OFS_FRAME_FORMAT_SELECT: begin
					next_state.prdata = {24'h00_0000, state.format};
					if (apb_write) begin
						next_state.format = pwdata[7:0];
					end
				end
				sertx_pkg::OFS_TX_STATUS: begin
					next_state.prdata = {30'h0000_0000, state.tx_busy,
						state.empty_flag};
				end
				sertx_pkg::OFS_TX_CONTROL: begin
					next_state.prdata = {31'h0000_0000, state.tx_enable};
					if (apb_write) begin
						next_state.tx_enable = pwdata[0];
					end
				end
				default: begin
					next_state.pslverr = 1'b1;
				end
			endcase
		end
		if (!state.tx_enable) begin
			next_state.empty_flag = 1'b1;
		end
		// Frame sequencing on the bit clock.
		case (state.fsm)
			sertx_pkg::ST_IDLE: begin
				next_state.txd = 1'b1;
				next_state.sclk_out = 1'b1;
				next_state.tx_busy = 1'b0;
			end
			sertx_pkg::ST_START: begin
				if (bit_tick) begin
					next_state.fsm = sertx_pkg::ST_DATA;
					next_state.txd = state.shifter[0];
				end
			end
			sertx_pkg::ST_DATA: begin
				if (state.cfg.sync_mode & bit_tick) begin
					next_state.sclk_out = ~state.sclk_out;
				end
				if (bit_tick & (~state.cfg.sync_mode | state.sclk_out)) begin
					next_state.parity_acc = state.parity_acc ^ state.shifter[0];
					next_state.shifter = {1'b0, state.shifter[7:1]};
					next_state.bit_count = 4'(state.bit_count + 4'h1);
					if (4'(state.bit_count + 4'h1) == state.bits_total) begin
						if (state.cfg.extra_bit) begin
							next_state.fsm = sertx_pkg::ST_EXTRA;
							next_state.txd = state.cfg.extra_is_parity ?
								(state.parity_acc ^ state.shifter[0] ^
								state.cfg.parity_odd) : 1'b0;
						end else if (state.cfg.sync_mode) begin
							next_state.fsm = sertx_pkg::ST_IDLE;
							next_state.txd = 1'b1;
							next_state.sclk_out = 1'b1;
						end else begin
							next_state.fsm = sertx_pkg::ST_STOP;
							next_state.txd = 1'b1;
							next_state.stop_left = state.cfg.two_stop;
						end
					end else begin
						next_state.txd = state.shifter[1];
					end
				end
			end
			sertx_pkg::ST_EXTRA: begin
				if (bit_tick) begin
					next_state.fsm = sertx_pkg::ST_STOP;
					next_state.txd = 1'b1;
					next_state.stop_left = state.cfg.two_stop;
				end
			end
			sertx_pkg::ST_STOP: begin
				// stop stays high for the far end
				if (bit_tick) begin
					if (state.stop_left) begin
						next_state.stop_left = 1'b0;
					end else begin
						next_state.fsm = sertx_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				next_state.fsm = sertx_pkg::ST_IDLE;
			end
		endcase
		// load a free shifter, even at the last stop bit
		if (load_now) begin
			next_state.cfg = decode_cfg(state.format);
			next_state.shifter = state.holding &
				length_mask(next_state.cfg.data_bits);
			next_state.bits_total = next_state.cfg.data_bits;
			// A byte written in this same cycle stays pending.
			next_state.empty_flag = ~hold_write;
			next_state.bit_count = 4'h0;
			next_state.parity_acc = 1'b0;
			next_state.tx_busy = 1'b1;
			if (next_state.cfg.sync_mode) begin
				next_state.fsm = sertx_pkg::ST_DATA;
				next_state.txd = state.holding[0];
				next_state.sclk_out = 1'b0;
			end else begin
				next_state.fsm = sertx_pkg::ST_START;
				next_state.txd = 1'b0;
			end
		end
		if (standby_enter) begin
			next_state.holding = sertx_pkg::RST_TRANSMIT_HOLDING;
			next_state.format = sertx_pkg::RST_FRAME_FORMAT;
		end
	end

	// Register all state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= '0;
			state.holding <= sertx_pkg::RST_TRANSMIT_HOLDING;
			state.format <= sertx_pkg::RST_FRAME_FORMAT;
			state.empty_flag <= 1'b1;
			state.txd <= 1'b1;
			state.sclk_out <= 1'b1;
			state.fsm <= sertx_pkg::ST_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	assign prdata = state.prdata;
	assign pready = state.pready;
	assign pslverr = state.pslverr;
	assign txd = state.txd;
	assign sclk_out = state.sclk_out;
	assign prescale_tick = state.prescale_tick;
	assign tx_busy = state.tx_busy;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence seq_apb_access;
		psel & penable & ~pready;
	endsequence

	AST_HOLD_RESET: assert property (@(posedge pclk)
		$rose(presetn) |-> state.holding == 8'hFF)
		else $error("Holding register not all ones after reset.");
	AST_FORMAT_RESET: assert property (@(posedge pclk)
		$rose(presetn) |-> state.format == 8'h00)
		else $error("Format register not zero after reset.");
	AST_STANDBY: assert property (@(posedge pclk) disable iff (!presetn)
		standby_enter & clk_en |=> state.holding == 8'hFF &&
		state.format == 8'h00)
		else $error("Standby did not reinitialise registers.");
	AST_APB_ANSWER: assert property (@(posedge pclk)
		disable iff (!presetn) seq_apb_access ##0 clk_en |=> pready)
		else $error("APB access not answered in one cycle.");
	AST_NO_LOAD_EMPTY: assert property (@(posedge pclk)
		disable iff (!presetn) state.fsm == sertx_pkg::ST_IDLE &&
		state.empty_flag |=> state.fsm == sertx_pkg::ST_IDLE)
		else $error("Shifter loaded without new byte.");
	AST_LOAD_SETS_EMPTY: assert property (@(posedge pclk)
		disable iff (!presetn) $past(state.fsm) == sertx_pkg::ST_IDLE &&
		state.fsm != sertx_pkg::ST_IDLE && !$past(hold_write) |->
		state.empty_flag)
		else $error("Load did not free holding register.");
	AST_BACK_TO_BACK: assert property (@(posedge pclk)
		disable iff (!presetn) state.fsm == sertx_pkg::ST_STOP &&
		!state.stop_left && bit_tick && clk_en && state.tx_enable &&
		!state.empty_flag |=> state.fsm != sertx_pkg::ST_IDLE)
		else $error("Pending byte not sent straight after stop.");
	AST_START_LOW: assert property (@(posedge pclk)
		disable iff (!presetn) state.fsm == sertx_pkg::ST_START |-> !txd)
		else $error("Start bit not low.");
	AST_STOP_HIGH: assert property (@(posedge pclk)
		disable iff (!presetn) state.fsm == sertx_pkg::ST_STOP |-> txd)
		else $error("Stop bit not high.");
	AST_SYNC_NO_EXTRA: assert property (@(posedge pclk)
		disable iff (!presetn) state.cfg.sync_mode |->
		state.fsm != sertx_pkg::ST_EXTRA && state.fsm != sertx_pkg::ST_START)
		else $error("Synchronous frame carried framing bits.");
	AST_IDLE_HIGH: assert property (@(posedge pclk)
		disable iff (!presetn) state.fsm == sertx_pkg::ST_IDLE &&
		$past(state.fsm) == sertx_pkg::ST_IDLE |-> txd)
		else $error("Idle line not high.");
endmodule
`default_nettype wire

// [bench/sertx_rx_model.sv]
// Far-end receiver model that decodes asynchronous frames from the line.
`default_nettype none
module sertx_rx_model (
	// Clock and bit timing.
	input wire logic pclk,
	input wire logic bit_tick,
	// Serial line and expected frame shape.
	input wire logic txd,
	input wire logic sclk_out,
	input wire logic [3:0] nbits,
	input wire logic extra_en
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	logic [7:0] sh;
	logic ex;
	logic [9:0] q[$];
	int gap = 0;
	int last_gap = 0;
	logic [7:0] sync_rx = 8'h00;
	int sync_cnt = 0;
	// synchronous far end takes data on rising serial clock.
	always @(posedge sclk_out) begin
		sync_rx = {txd, sync_rx[7:1]};
		sync_cnt++;
	end
	// ------------------------------------------------------------
	// Frame decoder
	// ------------------------------------------------------------
	// start, data, stop
	// One sample per bit period; only the first stop bit is judged, so a
	// low second stop bit is taken as the start of the next character.
	always @(posedge pclk) begin
		if (bit_tick === 1'b1) begin
			if (cnt == 0) begin
				if (txd === 1'b0) begin
					cnt = 1;
					sh = 8'h00;
					ex = 1'b0;
					last_gap = gap;
				end else begin
					gap++;
				end
			end else if (cnt <= nbits) begin
				sh[cnt-1] = txd;
				cnt++;
			end else if (extra_en && cnt == nbits + 1) begin
				ex = txd;
				cnt++;
			end else begin
				q.push_back({txd, ex, sh});
				cnt = 0;
				gap = 0;
			end
		end
	end
endmodule
`default_nettype wire

// [bench/test_serial_tx_data_and_format_control.sv]
// Self-checking bench for the serial transmitter and its registers.
`default_nettype none
module test_serial_tx_data_and_format_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, clk_en, psel, penable, pwrite, standby_enter;
	logic sub_tick, sub_low_power, bit_tick, txd, sclk_out;
	logic prescale_tick, tx_busy, pready, pslverr, extra_en;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rnd;
	logic [3:0] nbits, tc;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	// ------------------------------------------------------------
	// Design, far end and clocks
	// ------------------------------------------------------------
	sertx_top uut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .standby_enter(standby_enter),
		.sub_tick(sub_tick), .sub_low_power(sub_low_power),
		.bit_tick(bit_tick), .txd(txd), .sclk_out(sclk_out),
		.prescale_tick(prescale_tick), .tx_busy(tx_busy));
	sertx_rx_model rx (.pclk(pclk), .bit_tick(bit_tick), .txd(txd),
		.sclk_out(sclk_out), .nbits(nbits), .extra_en(extra_en));
	// The clock toggles every 4 ns, half of its 8 ns period.
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// Bit and subclock ticks both recur every four cycles.
	always @(posedge pclk) begin
		tc <= tc + 4'h1;
		bit_tick <= (tc[1:0] == 2'h3);
		sub_tick <= (tc[1:0] == 2'h1);
	end
	// A hang counts as a mismatch and ends the run.
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			summarize();
		end
	end
	// ------------------------------------------------------------
	// Tasks and reference model
	// ------------------------------------------------------------
	// One APB transfer; the request stands until pready is seen high, for at most 50 cycles.
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		check({31'h0, pready}, 32'h0000_0001, "apb answer");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t %s got %h want %h", $time, msg,
				seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Stop flag, extra bit and masked data as the far end should see them.
	function automatic logic [9:0] exp_frame(input logic [7:0] f,
		input logic [7:0] d);
		logic [7:0] m;
		m = d & ((f[5] & f[2]) ? 8'h1F : (f[6] ? 8'h7F : 8'hFF));
		return {1'b1, f[5] & (^m ^ f[4]), m};
	endfunction
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		logic [7:0] b [2];
		logic [7:0] fmts [8];
		int cnts [5];
		int n;
		fmts = '{8'h00, 8'h48, 8'h20, 8'h30, 8'h70, 8'h24, 8'h3C, 8'h04};
		cnts = '{256, 32, 16, 4, 64};
		rnd = 32'had98_c701;
		{presetn, psel, penable, pwrite, standby_enter} = 5'h00;
		{sub_low_power, bit_tick, sub_tick, extra_en} = 4'h0;
		clk_en = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		nbits = 4'h8;
		tc = 4'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, sertx_pkg::OFS_TRANSMIT_HOLDING, 32'h0, r, e);
		check(r, {24'h0, sertx_pkg::RST_TRANSMIT_HOLDING}, "hold rst");
		apb(1'b0, sertx_pkg::OFS_FRAME_FORMAT_SELECT, 32'h0, r, e);
		check(r, {24'h0, sertx_pkg::RST_FRAME_FORMAT}, "fmt rst");
		apb(1'b0, 12'h010, 32'h0, r, e);
		check({31'h0, e}, 32'h0000_0001, "unmapped error");
		$display("test reset and map done");
		apb(1'b1, sertx_pkg::OFS_TX_CONTROL, 32'h0000_0001, r, e);
		foreach (fmts[i]) begin
			apb(1'b1, sertx_pkg::OFS_FRAME_FORMAT_SELECT, {24'h0, fmts[i]}, r, e);
			apb(1'b0, sertx_pkg::OFS_FRAME_FORMAT_SELECT, 32'h0, r, e);
			check(r, {24'h0, fmts[i]}, "fmt readback");
			nbits = (fmts[i][5] & fmts[i][2]) ? 4'h5 : (fmts[i][6] ? 4'h7 : 4'h8);
			extra_en = fmts[i][5] | fmts[i][2];
			// Second byte goes in while the first is still shifting out.
			for (int k = 0; k < 2; k++) begin
				rnd = lfsr(rnd);
				b[k] = rnd[7:0];
				apb(1'b1, sertx_pkg::OFS_TRANSMIT_HOLDING, {24'h0, b[k]}, r, e);
				n = 0;
				r = 32'h0;
				while (r[0] !== 1'b1 && n < 40) begin
					apb(1'b0, sertx_pkg::OFS_TX_STATUS, 32'h0, r, e);
					n++;
				end
				check({31'h0, r[0]}, 32'h0000_0001, "loaded");
			end
			n = 0;
			while (rx.q.size() < 2 && n < 400) begin
				@(posedge pclk);
				n++;
			end
			check(rx.q.size(), 2, "frame count");
			for (int k = 0; k < 2; k++) begin
				if (rx.q.size() > 0) begin
					check({22'h0, rx.q.pop_front()}, {22'h0, exp_frame(fmts[i], b[k])},
						"frame");
				end
			end
			// Only the second stop bit may stand between the two frames.
			check(rx.last_gap, {31'h0, fmts[i][3]}, "stop gap");
			n = 0;
			while (tx_busy !== 1'b0 && n < 200) begin
				@(posedge pclk);
				n++;
			end
			check({31'h0, tx_busy}, 32'h0, "busy end");
			repeat (60) @(posedge pclk);
			check(rx.q.size(), 0, "no extra frame");
		end
		$display("test frame formats done");
		// Synchronous mode ignores length, parity and stop settings.
		apb(1'b1, sertx_pkg::OFS_FRAME_FORMAT_SELECT, 32'h0000_00F8, r, e);
		rnd = lfsr(rnd);
		n = rx.sync_cnt;
		apb(1'b1, sertx_pkg::OFS_TRANSMIT_HOLDING, {24'h0, rnd[7:0]}, r, e);
		repeat (100) @(posedge pclk);
		check(rx.sync_cnt - n, 8, "sync clocks");
		check({24'h0, rx.sync_rx}, {24'h0, rnd[7:0]}, "sync");
		check({31'h0, sclk_out}, 32'h0000_0001, "sync idle");
		rx.q.delete();
		$display("test synchronous done");
		for (int c = 0; c < 5; c++) begin
			sub_low_power <= (c == 4);
			apb(1'b1, sertx_pkg::OFS_FRAME_FORMAT_SELECT,
				{30'h0, (c == 4) ? 2'h1 : 2'(c)}, r, e);
			repeat (128) @(posedge pclk);
			n = 0;
			repeat (256) begin
				@(posedge pclk);
				if (prescale_tick === 1'b1) n++;
			end
			check(n, cnts[c], "prescale ticks");
		end
		$display("test prescale done");
		apb(1'b1, sertx_pkg::OFS_TRANSMIT_HOLDING, 32'h0000_00A5, r, e);
		apb(1'b0, sertx_pkg::OFS_TRANSMIT_HOLDING, 32'h0, r, e);
		check(r, 32'h0000_00A5, "hold readback");
		// With the clock enable low, a standby request must not land.
		@(posedge pclk);
		clk_en <= 1'b0;
		standby_enter <= 1'b1;
		@(posedge pclk);
		standby_enter <= 1'b0;
		@(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b0, sertx_pkg::OFS_TRANSMIT_HOLDING, 32'h0, r, e);
		check(r, 32'h0000_00A5, "hold frozen");
		@(posedge pclk);
		standby_enter <= 1'b1;
		@(posedge pclk);
		standby_enter <= 1'b0;
		apb(1'b0, sertx_pkg::OFS_TRANSMIT_HOLDING, 32'h0, r, e);
		check(r, {24'h0, sertx_pkg::RST_TRANSMIT_HOLDING}, "hold stby");
		apb(1'b0, sertx_pkg::OFS_FRAME_FORMAT_SELECT, 32'h0, r, e);
		check(r, {24'h0, sertx_pkg::RST_FRAME_FORMAT}, "fmt stby");
		$display("test standby done");
		summarize();
	end
endmodule
`default_nettype wire
